//--- hw/dcmt_pkg.sv
package dcmt_pkg;

  // memory technology and transfer rate selectors
  localparam logic       TECH_DDR3L       = 1'b0;
  localparam logic       TECH_LPDDR3      = 1'b1;
  localparam logic       RATE_1333        = 1'b0;
  localparam logic       RATE_1600        = 1'b1;

  // timing figures in memory clocks, per technology and rate
  localparam logic [4:0] DDR3L_1333_BASE  = 5'h08;  // 8 or 9
  localparam logic [4:0] DDR3L_1333_CWL   = 5'h07;
  localparam logic [4:0] DDR3L_1600_BASE  = 5'h0a;  // 10 or 11
  localparam logic [4:0] DDR3L_1600_CWL   = 5'h08;
  localparam logic [4:0] LP_1333_CL       = 5'h0a;
  localparam logic [4:0] LP_1333_RCD      = 5'h0c;
  localparam logic [4:0] LP_1333_CWL      = 5'h07;
  localparam logic [4:0] LP_1600_CL       = 5'h0c;
  localparam logic [4:0] LP_1600_RCD      = 5'h0f;
  localparam logic [4:0] LP_1600_CWL      = 5'h08;

  // burst length in data transfers, same for every mode
  localparam logic [3:0] BURST_LENGTH     = 4'h8;

  // address layout: 64-byte cache line
  localparam int         ADDR_W           = 36;
  localparam int         LINE_BIT         = 6;

  // memory-down geometry
  localparam logic [3:0] BANKS_PER_DIE    = 4'h8;
  localparam logic [1:0] MAX_RANKS        = 2'h2;

  // command rate encodings
  typedef enum logic [2:0] {
    DCMT_CMD_ONE  = 3'b001,
    DCMT_CMD_TWO  = 3'b010,
    DCMT_CMD_HALF = 3'b100
  } dcmt_cmd_rate_type;

  // organization modes
  typedef enum logic [3:0] {
    DCMT_ORG_NONE   = 4'b0001,
    DCMT_ORG_SINGLE = 4'b0010,
    DCMT_ORG_ASYM   = 4'b0100,
    DCMT_ORG_FULL   = 4'b1000
  } dcmt_org_type;

  // issue state machine
  typedef enum logic [1:0] {
    DCMT_ST_IDLE = 2'b01,
    DCMT_ST_GAP  = 2'b10
  } dcmt_state_type;

  localparam logic [4:0] RESET_TIMING     = 5'h00;

endpackage

//--- hw/dcmt_timing_select.sv
`timescale 1ns/100ps
// picks the timing set from technology, rate and slow-bin choice
module dcmt_timing_select
  import dcmt_pkg::*;
(
  input  wire logic       i_tech,        // TECH_DDR3L or TECH_LPDDR3
  input  wire logic       i_rate,        // RATE_1333 or RATE_1600
  input  wire logic       i_slow_bin,    // ddr3l: add one clock to the base bin
  input  wire logic       i_two_clock,   // ddr3l: ask for two-clock command rate
  output logic [4:0]      o_cas_read_latency,
  output logic [4:0]      o_activate_to_column_delay,
  output logic [4:0]      o_precharge_period,
  output logic [4:0]      o_cas_write_latency,
  output dcmt_cmd_rate_type o_rate
);

  // one table lookup, purely combinational
  always_comb begin
    o_cas_read_latency         = RESET_TIMING;
    o_activate_to_column_delay = RESET_TIMING;
    o_precharge_period         = RESET_TIMING;
    o_cas_write_latency        = RESET_TIMING;
    o_rate                     = DCMT_CMD_ONE;
    if (i_tech == TECH_DDR3L) begin
      o_cas_read_latency = (i_rate == RATE_1600) ? DDR3L_1600_BASE : DDR3L_1333_BASE;
      if (i_slow_bin) begin
        o_cas_read_latency = o_cas_read_latency + 5'h01;
      end
      // one bin value covers all three timings; finer steps need a wider port
      o_activate_to_column_delay = o_cas_read_latency;
      o_precharge_period         = o_cas_read_latency;
      o_cas_write_latency = (i_rate == RATE_1600) ? DDR3L_1600_CWL : DDR3L_1333_CWL;
      o_rate = i_two_clock ? DCMT_CMD_TWO : DCMT_CMD_ONE;
    end else begin
      o_cas_read_latency         = (i_rate == RATE_1600) ? LP_1600_CL : LP_1333_CL;
      o_activate_to_column_delay = (i_rate == RATE_1600) ? LP_1600_RCD : LP_1333_RCD;
      o_precharge_period         = o_activate_to_column_delay;
      o_cas_write_latency        = (i_rate == RATE_1600) ? LP_1600_CWL : LP_1333_CWL;
      o_rate                     = DCMT_CMD_HALF;
    end
  end

endmodule // dcmt_timing_select

//--- hw/dcmt_core.sv
`timescale 1ns/100ps
// Operation
// - one-clock or two-clock command spacing supported
// - ddr3l 1333: 8/9 timings, write latency 7
// - ddr3l 1600: 10/11 timings, write latency 8
// - lpddr3 uses half-clock rate, fixed timings
// - single populated channel receives every request
// - low zone interleaved, upper zone single channel
// - logical A/B map to physical, swappable
// - interleave flips channel each 64-byte line
// - opposite-channel request issues without waiting at one-clock and half-clock rate; two-clock rate adds a one-clock gap
// - consecutive lines fetched together on both channels
// - equal capacity, boundary at top: fully interleaved
// - channels may differ in technology and width
// - memory-down: one or two ranks, 8 banks
// - burst length eight in every mode
module dcmt_core
  import dcmt_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // configuration, held stable while traffic runs
  input  wire logic              i_tech,           // shared timing-set technology
  input  wire logic              i_rate,           // transfer rate select
  input  wire logic              i_slow_bin,       // ddr3l upper bin
  input  wire logic              i_two_clock,      // ddr3l two-clock command rate
  input  wire logic              i_chan_a_present, // logical channel a populated
  input  wire logic              i_chan_b_present, // logical channel b populated
  input  wire logic              i_swap,           // a on physical 1, b on physical 0
  input  wire logic [ADDR_W-1:0] i_chan_a_size,    // bytes on logical a
  input  wire logic [ADDR_W-1:0] i_chan_b_size,    // bytes on logical b
  input  wire logic [ADDR_W-1:0] i_zone_boundary,  // top of interleaved zone
  input  wire logic [1:0]        i_chan0_ranks,    // memory-down ranks, physical 0
  input  wire logic [1:0]        i_chan1_ranks,    // memory-down ranks, physical 1
  // request path
  input  wire logic              i_req_valid,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  output logic                   o_req_ready,
  // two physical channel command ports
  output logic [1:0]             o_cmd_valid,      // one bit per physical channel
  output logic [ADDR_W-1:0]      o_cmd_addr0,
  output logic [ADDR_W-1:0]      o_cmd_addr1,
  input  wire logic [1:0]        i_chan_ready,     // channel can take a command
  // status
  output dcmt_org_type           o_org_mode,
  output dcmt_cmd_rate_type      o_cmd_rate,
  output logic [4:0]             o_cas_read_latency,
  output logic [4:0]             o_activate_to_column_delay,
  output logic [4:0]             o_precharge_period,
  output logic [4:0]             o_cas_write_latency,
  output logic [3:0]             o_burst_length,
  output logic [3:0]             o_banks_per_die,
  output logic                   o_config_error    // a smaller than b, or bad rank count
);

  // all registered state in one struct
  typedef struct packed {
    dcmt_state_type    st;
    logic [1:0]        gap;       // clocks left before next command slot
    logic [1:0]        cmd_valid;
    logic [ADDR_W-1:0] addr0;
    logic [ADDR_W-1:0] addr1;
    dcmt_org_type      org;
    dcmt_cmd_rate_type rate;
    logic [4:0]        cl;
    logic [4:0]        rcd;
    logic [4:0]        rp;
    logic [4:0]        cas_write_latency;
    logic              err;
  } dcmt_regs_type;

  dcmt_regs_type     r_q;          // registered state
  dcmt_regs_type     r_d;          // next state
  logic [4:0]        sel_cl;       // looked-up timings
  logic [4:0]        sel_rcd;
  logic [4:0]        sel_rp;
  logic [4:0]        sel_cwl;
  dcmt_cmd_rate_type sel_rate;
  logic              log_chan;     // logical target: 0 = a, 1 = b
  logic              phys_chan;    // physical target
  logic              in_zone;      // address below interleave boundary
  logic [ADDR_W-1:0] zone_top;     // effective interleave top
  logic              slot_free;    // command spacing allows a launch
  logic              take;         // request accepted this clock

  // map logical channel to physical
  function automatic logic to_phys(input logic lch, input logic swp);
    return lch ^ swp;
  endfunction

  // timing table; one set serves both channels since firmware writes the slower
  dcmt_timing_select u_timing (
    .i_tech                     (i_tech),
    .i_rate                     (i_rate),
    .i_slow_bin                 (i_slow_bin),
    .i_two_clock                (i_two_clock),
    .o_cas_read_latency         (sel_cl),
    .o_activate_to_column_delay (sel_rcd),
    .o_precharge_period         (sel_rp),
    .o_cas_write_latency        (sel_cwl),
    .o_rate                     (sel_rate)
  );

  // steering decision, combinational from request address
  always_comb begin
    // boundary compare
    // interleave top is the smaller of boundary and channel b size, doubled
    zone_top = (i_zone_boundary < {i_chan_b_size[ADDR_W-2:0], 1'b0}) ?
               i_zone_boundary : {i_chan_b_size[ADDR_W-2:0], 1'b0};
    in_zone  = (i_req_addr < zone_top);
    log_chan = 1'b0;
    unique case (r_q.org)
      DCMT_ORG_SINGLE: begin
        log_chan = i_chan_a_present ? 1'b0 : 1'b1;
      end
      DCMT_ORG_FULL: begin
        log_chan = i_req_addr[LINE_BIT];
      end
      DCMT_ORG_ASYM: begin
        // zone split; upper zone lives on larger channel a
        log_chan = in_zone ? i_req_addr[LINE_BIT] : 1'b0;
      end
      DCMT_ORG_NONE: begin
        log_chan = 1'b0;
      end
    endcase
    phys_chan = to_phys(log_chan, i_swap);
  end

  assign slot_free   = (r_q.st == DCMT_ST_IDLE);
  // only target channel's ready matters, other channel's pending work ignored
  assign take        = i_req_valid && slot_free && (r_q.org != DCMT_ORG_NONE) &&
                       !r_q.cmd_valid[phys_chan] && i_chan_ready[phys_chan];
  assign o_req_ready = slot_free && (r_q.org != DCMT_ORG_NONE) &&
                       !r_q.cmd_valid[phys_chan] && i_chan_ready[phys_chan];

  // next-state logic
  always_comb begin
    r_d = r_q;
    // mode and timing follow configuration; firmware changes them only when idle
    r_d.cl  = sel_cl;
    r_d.rcd = sel_rcd;
    r_d.rp  = sel_rp;
    r_d.cas_write_latency = sel_cwl;
    r_d.rate = sel_rate;
    // per-channel technology not checked, only presence, size and rank count
    if (i_chan_a_present && i_chan_b_present) begin
      r_d.org = ((i_chan_a_size == i_chan_b_size) &&
                 (i_zone_boundary >= {i_chan_a_size[ADDR_W-2:0], 1'b0})) ?
                DCMT_ORG_FULL : DCMT_ORG_ASYM;
    end else if (i_chan_a_present || i_chan_b_present) begin
      r_d.org = DCMT_ORG_SINGLE;
    end else begin
      r_d.org = DCMT_ORG_NONE;
    end
    r_d.err = (i_chan_a_present && i_chan_b_present && (i_chan_a_size < i_chan_b_size)) ||
              (i_chan0_ranks == 2'h0) || (i_chan0_ranks > MAX_RANKS) ||
              (i_chan1_ranks == 2'h0) || (i_chan1_ranks > MAX_RANKS);
    // a channel drops its command once it accepts it
    for (int c = 0; c < 2; c++) begin
      if (r_q.cmd_valid[c] && i_chan_ready[c]) begin
        r_d.cmd_valid[c] = 1'b0;
      end
    end
    // issue spacing machine
    unique case (r_q.st)
      DCMT_ST_IDLE: begin
        if (take) begin
          // other channel may still hold its line: both fetch together
          r_d.cmd_valid[phys_chan] = 1'b1;
          if (phys_chan) begin
            r_d.addr1 = i_req_addr;
          end else begin
            r_d.addr0 = i_req_addr;
          end
          if (r_q.rate == DCMT_CMD_TWO) begin
            r_d.st  = DCMT_ST_GAP;
            r_d.gap = 2'h1;
          end
        end
      end
      DCMT_ST_GAP: begin
        r_d.gap = r_q.gap - 2'h1;
        if (r_q.gap == 2'h1) begin
          r_d.st = DCMT_ST_IDLE;
        end
      end
    endcase
  end

  // register the whole state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r_q.st        <= DCMT_ST_IDLE;
      r_q.gap       <= 2'h0;
      r_q.cmd_valid <= 2'h0;
      r_q.addr0     <= '0;
      r_q.addr1     <= '0;
      r_q.org       <= DCMT_ORG_NONE;
      r_q.rate      <= DCMT_CMD_ONE;
      r_q.cl        <= RESET_TIMING;
      r_q.rcd       <= RESET_TIMING;
      r_q.rp        <= RESET_TIMING;
      r_q.cas_write_latency       <= RESET_TIMING;
      r_q.err       <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs from flip-flops; burst length and banks per die are constants
  assign o_cmd_valid                = r_q.cmd_valid;
  assign o_cmd_addr0                = r_q.addr0;
  assign o_cmd_addr1                = r_q.addr1;
  assign o_org_mode                 = r_q.org;
  assign o_cmd_rate                 = r_q.rate;
  assign o_cas_read_latency         = r_q.cl;
  assign o_activate_to_column_delay = r_q.rcd;
  assign o_precharge_period         = r_q.rp;
  assign o_cas_write_latency        = r_q.cas_write_latency;
  assign o_burst_length             = BURST_LENGTH;
  assign o_banks_per_die            = BANKS_PER_DIE;
  assign o_config_error             = r_q.err;

endmodule // dcmt_core

//--- bench/dcmt_core_checker.sv
`timescale 1ns/100ps
// watches steering, timing and spacing at the core's ports
module dcmt_core_checker
  import dcmt_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_reset,
  input wire logic              i_tech,
  input wire logic              i_rate,
  input wire logic              i_slow_bin,
  input wire logic              i_two_clock,
  input wire logic              i_chan_a_present,
  input wire logic              i_chan_b_present,
  input wire logic              i_swap,
  input wire logic [ADDR_W-1:0] i_chan_a_size,
  input wire logic [ADDR_W-1:0] i_chan_b_size,
  input wire logic              i_req_valid,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic              o_req_ready,
  input wire logic [1:0]        o_cmd_valid,
  input wire logic [1:0]        i_chan_ready,
  input wire dcmt_org_type      o_org_mode,
  input wire dcmt_cmd_rate_type o_cmd_rate,
  input wire logic [4:0]        o_cas_read_latency,
  input wire logic [4:0]        o_cas_write_latency,
  input wire logic              o_config_error
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic take;      // request accepted this edge
  logic full_tgt;  // expected channel when interleaved
  logic one_tgt;   // expected channel with one channel fitted
  assign take     = i_req_valid && o_req_ready;
  assign full_tgt = i_req_addr[LINE_BIT] ^ i_swap;
  assign one_tgt  = i_chan_b_present ^ i_swap;
  property p_lp; i_tech |=> o_cmd_rate == DCMT_CMD_HALF; endproperty
  a_lp: assert property (p_lp) else $error("lpddr3 rate wrong");
  property p_d13; !i_tech && !i_rate |=> o_cas_write_latency == DDR3L_1333_CWL
    && o_cas_read_latency == DDR3L_1333_BASE + $past(i_slow_bin); endproperty
  a_d13: assert property (p_d13) else $error("ddr3l 1333 timing wrong");
  property p_d16; !i_tech && i_rate |=> o_cas_write_latency == DDR3L_1600_CWL
    && o_cas_read_latency == DDR3L_1600_BASE + $past(i_slow_bin)
    && o_cmd_rate == ($past(i_two_clock) ? DCMT_CMD_TWO : DCMT_CMD_ONE); endproperty
  a_d16: assert property (p_d16) else $error("ddr3l 1600 timing wrong");
  property p_gap; o_cmd_rate == DCMT_CMD_TWO && take |=> !o_req_ready; endproperty
  a_gap: assert property (p_gap) else $error("two-clock gap missing");
  property p_full; o_org_mode == DCMT_ORG_FULL && take |=> o_cmd_valid[$past(full_tgt)];
  endproperty
  a_full: assert property (p_full) else $error("interleave channel wrong");
  property p_one; o_org_mode == DCMT_ORG_SINGLE && take |=> o_cmd_valid[$past(one_tgt)];
  endproperty
  a_one: assert property (p_one) else $error("single channel target wrong");
  property p_opp; o_org_mode == DCMT_ORG_FULL && o_cmd_rate != DCMT_CMD_TWO
    && o_cmd_valid == 2'h2 && i_chan_ready == 2'h1 && i_req_valid && !full_tgt
    |-> o_req_ready; endproperty
  a_opp: assert property (p_opp) else $error("opposite channel blocked");
  property p_err; i_chan_a_present && i_chan_b_present && i_chan_a_size < i_chan_b_size
    |=> o_config_error; endproperty
  a_err: assert property (p_err) else $error("size order not flagged");
  c_asym: cover property (take && o_org_mode == DCMT_ORG_ASYM);
  c_both: cover property (o_cmd_valid == 2'h3);
  c_two:  cover property (take && o_cmd_rate == DCMT_CMD_TWO);
endmodule // dcmt_core_checker

bind dcmt_core dcmt_core_checker u_chk (.i_clk, .i_reset, .i_tech, .i_rate, .i_slow_bin,
  .i_two_clock, .i_chan_a_present, .i_chan_b_present, .i_swap, .i_chan_a_size,
  .i_chan_b_size, .i_req_valid, .i_req_addr, .o_req_ready, .o_cmd_valid, .i_chan_ready,
  .o_org_mode, .o_cmd_rate, .o_cas_read_latency, .o_cas_write_latency, .o_config_error);

//--- bench/dcmt_chan_model.sv
`timescale 1ns/100ps
// one physical channel; a slow one sits on a command for four clocks
module dcmt_chan_model (
  input  wire logic i_clk,
  input  wire logic i_valid,  // command offered
  input  wire logic i_slow,   // stall each command
  output logic      o_ready   // taken at edge with valid
);
  logic [1:0] cnt_q = 2'h0;   // clocks spent holding a command
  // count the stall, restart when idle
  always_ff @(posedge i_clk) begin
    cnt_q <= (i_valid && !o_ready) ? cnt_q + 2'h1 : 2'h0;
  end
  assign o_ready = !i_slow || !i_valid || cnt_q == 2'h3;
endmodule // dcmt_chan_model

//--- bench/dcmt_core_tb.sv
`timescale 1ns/100ps
// scenario bench for the mapping and timing core
module dcmt_core_tb
  import dcmt_pkg::*;
;
  logic i_clk = 1'b0, i_reset = 1'b1, i_tech = 1'b0, i_rate = 1'b0, i_slow_bin = 1'b0;
  logic i_two_clock = 1'b0, i_chan_a_present = 1'b0, i_chan_b_present = 1'b0, i_swap = 1'b0;
  logic [35:0] i_chan_a_size = '0, i_chan_b_size = '0, i_zone_boundary = '0, i_req_addr = '0;
  logic [1:0]  i_chan0_ranks = 2'h1, i_chan1_ranks = 2'h2, slow_ch = 2'h0;
  logic i_req_valid = 1'b0, o_req_ready, o_config_error;
  logic [1:0]  o_cmd_valid;
  wire  [1:0]  i_chan_ready;   // driven by the two channel models
  logic [35:0] o_cmd_addr0, o_cmd_addr1;
  dcmt_org_type o_org_mode;
  dcmt_cmd_rate_type o_cmd_rate;
  logic [4:0]  o_cas_read_latency, o_activate_to_column_delay, o_precharge_period;
  logic [4:0]  o_cas_write_latency;
  logic [3:0]  o_burst_length, o_banks_per_die;
  int          bad_count = 0, num_checks = 0;
  dcmt_core uut (.i_clk, .i_reset, .i_tech, .i_rate, .i_slow_bin, .i_two_clock,
    .i_chan_a_present, .i_chan_b_present, .i_swap, .i_chan_a_size, .i_chan_b_size,
    .i_zone_boundary, .i_chan0_ranks, .i_chan1_ranks, .i_req_valid, .i_req_addr,
    .o_req_ready, .o_cmd_valid, .o_cmd_addr0, .o_cmd_addr1, .i_chan_ready, .o_org_mode,
    .o_cmd_rate, .o_cas_read_latency, .o_activate_to_column_delay, .o_precharge_period,
    .o_cas_write_latency, .o_burst_length, .o_banks_per_die, .o_config_error);
  dcmt_chan_model u_m0 (.i_clk, .i_valid(o_cmd_valid[0]), .i_slow(slow_ch[0]),
    .o_ready(i_chan_ready[0]));
  dcmt_chan_model u_m1 (.i_clk, .i_valid(o_cmd_valid[1]), .i_slow(slow_ch[1]),
    .o_ready(i_chan_ready[1]));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move one step after the edge
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  // bounded wait for the condition, a hang ends the run
  task automatic await(input logic [1:0] sel);
    int n = 0;
    while ((sel[0] ? o_req_ready !== 1'b1 : o_cmd_valid !== 2'h0) && n < 40) begin
      tick();
      n++;
    end
    if (n == 40) begin
      bad_count++;
      stop_test();
    end
  endtask
  // configuration changes only once traffic has drained
  task automatic cfg(input logic a, b, s, input logic [35:0] sa, sb, zb);
    await(2'h0);
    {i_chan_a_present, i_chan_b_present, i_swap} = {a, b, s};
    {i_chan_a_size, i_chan_b_size, i_zone_boundary} = {sa, sb, zb};
    tick();
    tick();
  endtask
  // valid stays up so a following send is back to back
  task automatic send(input logic [35:0] a, input logic t);
    i_req_valid = 1'b1;
    i_req_addr = a;
    await(2'h1);
    tick();
    chk(o_cmd_valid[t], 1'b1);
    chk(t ? o_cmd_addr1 : o_cmd_addr0, a);
  endtask
  task automatic t_timing();
    logic [4:0] cl, rcd, cas_write_latency;
    for (int k = 0; k < 8; k++) begin
      {i_tech, i_rate, i_slow_bin} = k[2:0];
      i_two_clock = k[0];
      tick();
      tick();
      cas_write_latency = i_rate ? (i_tech ? LP_1600_CWL : DDR3L_1600_CWL)
                   : (i_tech ? LP_1333_CWL : DDR3L_1333_CWL);
      cl = (i_rate ? DDR3L_1600_BASE : DDR3L_1333_BASE) + {4'h0, i_slow_bin};
      rcd = i_tech ? (i_rate ? LP_1600_RCD : LP_1333_RCD) : cl;
      if (i_tech) cl = i_rate ? LP_1600_CL : LP_1333_CL;
      chk(o_cas_read_latency, cl);
      chk(o_activate_to_column_delay, rcd);
      chk(o_precharge_period, rcd);
      chk(o_cas_write_latency, cas_write_latency);
      chk(o_cmd_rate, i_tech ? DCMT_CMD_HALF : k[0] ? DCMT_CMD_TWO : DCMT_CMD_ONE);
      chk(o_burst_length, 4'h8);
      chk(o_banks_per_die, 4'h8);
    end
    {i_tech, i_two_clock} = 2'h0;
  endtask
  task automatic t_full();
    cfg(1'b1, 1'b1, 1'b0, 36'h1000, 36'h1000, 36'h2000);
    chk(o_org_mode, DCMT_ORG_FULL);
    slow_ch = 2'h2;
    send(36'h40, 1'b1);
    send(36'h80, 1'b0);
    i_req_valid = 1'b0;
    chk(o_cmd_valid, 2'h3);
    slow_ch = 2'h0;
    cfg(1'b1, 1'b1, 1'b1, 36'h1000, 36'h1000, 36'h2000);
    send(36'h40, 1'b0);
    i_req_valid = 1'b0;
  endtask
  task automatic t_asym();
    cfg(1'b1, 1'b1, 1'b0, 36'h2000, 36'h1000, 36'hf0000);
    chk(o_org_mode, DCMT_ORG_ASYM);
    send(36'h1fc0, 1'b1);
    send(36'h2040, 1'b0);
    i_req_valid = 1'b0;
    cfg(1'b1, 1'b1, 1'b0, 36'h2000, 36'h1000, 36'h1000);
    send(36'h0fc0, 1'b1);
    send(36'h1040, 1'b0);
    i_req_valid = 1'b0;
  endtask
  task automatic t_single();
    cfg(1'b0, 1'b1, 1'b0, 36'h0, 36'h1000, 36'h1000);
    chk(o_org_mode, DCMT_ORG_SINGLE);
    send(36'h40, 1'b1);
    send(36'h80, 1'b1);
    i_req_valid = 1'b0;
    cfg(1'b1, 1'b0, 1'b1, 36'h1000, 36'h0, 36'h1000);
    send(36'h80, 1'b1);
    i_req_valid = 1'b0;
  endtask
  task automatic t_two_err();
    i_two_clock = 1'b1;
    cfg(1'b1, 1'b1, 1'b0, 36'h1000, 36'h1000, 36'h2000);
    send(36'h40, 1'b1);
    chk(o_req_ready, 1'b0);
    send(36'h80, 1'b0);
    i_req_valid = 1'b0;
    cfg(1'b1, 1'b1, 1'b0, 36'h1000, 36'h2000, 36'h2000);
    chk(o_config_error, 1'b1);
    i_chan0_ranks = 2'h3;
    cfg(1'b1, 1'b1, 1'b0, 36'h1000, 36'h1000, 36'h2000);
    chk(o_config_error, 1'b1);
    i_chan0_ranks = 2'h2;
    cfg(1'b1, 1'b1, 1'b0, 36'h1000, 36'h1000, 36'h2000);
    chk(o_config_error, 1'b0);
    cfg(1'b0, 1'b0, 1'b0, 36'h0, 36'h0, 36'h0);
    chk(o_org_mode, DCMT_ORG_NONE);
    i_req_valid = 1'b1;
    i_req_addr = 36'h40;
    tick();
    chk(o_req_ready, 1'b0);
    chk(o_cmd_valid, 2'h0);
    i_req_valid = 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    chk(o_org_mode, DCMT_ORG_NONE);
    chk(o_req_ready, 1'b0);
    chk(o_cmd_rate, DCMT_CMD_ONE);
    chk(o_cas_read_latency, RESET_TIMING);
    i_reset = 1'b0;
    t_timing();
    t_full();
    t_asym();
    t_single();
    t_two_err();
    stop_test();
  end
endmodule // dcmt_core_tb
